// >>> hdl/ssp_port.sv
// SPI / I2S serial port with APB registers, one clock domain
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
//
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module ssp_port
    import ssp_pkg::*;
#(
    parameter int DW = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pclken,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire ssp_pkg::ssp_pins_t pin_in,
    output ssp_pkg::ssp_pins_t pin_out,
    output ssp_pkg::ssp_pins_t pin_oe,
    output logic irq
);
    import ssp_pkg::*;

    initial begin
        if (DW < 4 || DW > 16) $error("DW out of range");
    end

    // ------------------------------------------------------------------
    // Registers and state
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {IDLE, ARM, SHIFT} ssp_state_t;

    logic [15:0] ctrl_r;
    logic [15:0] crcp_r;
    logic [DW-1:0] txd_r;
    logic [DW-1:0] rxd_r;
    logic txe_r;
    logic receive_not_empty_flag_r;
    logic checksum_error_flag_r;
    logic [SSP_EV_W-1:0] irqs_r;
    logic [SSP_EV_W-1:0] imsk_r;
    ssp_state_t st_r;
    logic [DW-1:0] sh_r;
    logic [5:0] bit_r;
    logic [15:0] rcrc_r;
    logic [15:0] tcrc_r;
    logic crc_ph_r;
    logic [7:0] div_r;
    logic msck_r;
    logic mws_r;
    logic sck_d_r;
    logic last_r;
    ssp_pins_t pin_s;
    ssp_ev_t ev;

    logic wr;
    logic rd;
    logic en;
    logic master;
    logic i2s;
    ssp_std_t std;
    logic sck;
    logic rise;
    logic fall;
    logic smp;
    logic drv;
    logic ws_ok;
    logic crc_on;
    logic busy;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [15:0] crc_step(input logic [15:0] c,
            input logic b, input logic [15:0] poly);
        crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? poly : 16'h0000);
    endfunction : crc_step

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    ssp_sync #(.W(3)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .ce(pclken),
        .d(pin_in),
        .q(pin_s)
    );

    assign en = ctrl_r[SSP_CTL_EN];
    assign master = ctrl_r[SSP_CTL_MST];
    assign i2s = ctrl_r[SSP_CTL_I2S];
    assign std = ssp_std_t'(ctrl_r[SSP_CTL_STD0 +: 2]);
    assign crc_on = ctrl_r[SSP_CTL_CRCEN] & ~i2s;
    // Slave clock comes only through the synchroniser
    assign sck = master ? msck_r : pin_s.sck;
    assign rise = sck & ~sck_d_r;
    assign fall = ~sck & sck_d_r;
    assign smp = ctrl_r[SSP_CTL_CPOL] ? fall : rise;
    assign drv = ctrl_r[SSP_CTL_CPOL] ? rise : fall;
    // In I2S mode the slave starts only on word-select low under Philips, high under the other standards
    assign ws_ok = !i2s ? 1'b1 :
        (std == SSP_STD_PHILIPS) ? ~pin_s.ws : pin_s.ws;
    assign busy = master ? st_r != IDLE :
        st_r == SHIFT && (bit_r != 6'h00 || last_r);

    // ------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------
    assign wr = psel & penable & pwrite & pclken;
    assign rd = psel & penable & ~pwrite;
    assign pready = 1'b1;
    assign pslverr = psel & penable & (paddr[1:0] != 2'b00 ||
        paddr > SSP_OFS_IMSK);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (pclken && psel && !penable) begin
            unique case (paddr)
                SSP_OFS_CTRL: prdata <= {16'h0000, ctrl_r};
                SSP_OFS_STAT: prdata <= {28'h0000000, checksum_error_flag_r,
                    busy, receive_not_empty_flag_r, txe_r};
                SSP_OFS_DATA: prdata <= 32'(rxd_r);
                SSP_OFS_CRCP: prdata <= {16'h0000, crcp_r};
                SSP_OFS_RCRC: prdata <= {16'h0000, rcrc_r};
                SSP_OFS_TCRC: prdata <= {16'h0000, tcrc_r};
                SSP_OFS_IRQS: prdata <= {28'h0000000, irqs_r};
                SSP_OFS_IMSK: prdata <= {28'h0000000, imsk_r};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= SSP_CTRL_RST;
            crcp_r <= SSP_CRCP_RST;
            imsk_r <= '0;
        end else if (wr) begin
            // Enable may drop mid-frame; the engine finishes the frame
            if (paddr == SSP_OFS_CTRL) ctrl_r <= pwdata[15:0];
            if (paddr == SSP_OFS_CRCP) crcp_r <= pwdata[15:0];
            if (paddr == SSP_OFS_IMSK) imsk_r <= pwdata[SSP_EV_W-1:0];
        end
    end

    // ------------------------------------------------------------------
    // Master clock generation and delayed clock for edge detection
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_r <= 8'h00;
            msck_r <= 1'b0;
        end else if (pclken) begin
            if (st_r == SHIFT && master) begin
                if (div_r >= ctrl_r[SSP_CTL_DIV0 +: 8]) begin
                    div_r <= 8'h00;
                    msck_r <= ~msck_r;
                end else begin
                    div_r <= div_r + 8'h01;
                end
            end else begin
                div_r <= 8'h00;
                msck_r <= ctrl_r[SSP_CTL_CPOL];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_d_r <= 1'b0;
        end else if (pclken) begin
            sck_d_r <= sck;
        end
    end

    // ------------------------------------------------------------------
    // Shift engine
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= IDLE;
            sh_r <= '0;
            bit_r <= 6'h00;
            last_r <= 1'b0;
            crc_ph_r <= 1'b0;
            mws_r <= 1'b0;
        end else if (pclken) begin
            unique case (st_r)
                IDLE: begin
                    last_r <= 1'b0;
                    crc_ph_r <= 1'b0;
                    if (en && (!txe_r || ctrl_r[SSP_CTL_RXONLY] ||
                            !master)) begin
                        st_r <= ARM;
                        sh_r <= txd_r;
                        bit_r <= 6'h00;
                    end
                end
                ARM: begin
                    // Word-select sampled once; frame counter owns it after
                    if (master || ws_ok) begin
                        st_r <= SHIFT;
                        mws_r <= ~mws_r;
                    end else if (!en) begin
                        st_r <= IDLE;
                    end
                end
                SHIFT: begin
                    if (smp) begin
                        // Last bit lands in the shifter before any use
                        sh_r <= {sh_r[DW-2:0], pin_s.sd};
                        if (bit_r == 6'(DW - 1)) begin
                            bit_r <= 6'h00;
                            last_r <= 1'b1;
                        end else begin
                            bit_r <= bit_r + 6'h01;
                        end
                    end else if (last_r) begin
                        last_r <= 1'b0;
                        if (crc_on && !crc_ph_r && !en) begin
                            crc_ph_r <= 1'b1;
                            sh_r <= tcrc_r[DW-1:0];
                        end else if (en && !crc_ph_r &&
                                (!txe_r || !master)) begin
                            sh_r <= txd_r;
                            mws_r <= ~mws_r;
                        end else begin
                            st_r <= IDLE;
                        end
                    end else if (!en && !master && bit_r == 6'h00) begin
                        st_r <= IDLE;
                    end
                end
                default: st_r <= IDLE;
            endcase
        end
    end

    // Word completed in the cycle after its last sample edge
    assign ev.word = pclken && st_r == SHIFT && last_r && !smp &&
        !crc_ph_r;
    assign ev.load = pclken && ((st_r == IDLE && en && !txe_r &&
        (!ctrl_r[SSP_CTL_RXONLY] || !master)) ||
        (ev.word && en && !txe_r));
    assign ev.done = pclken && st_r == SHIFT && last_r && !smp &&
        !(en && !crc_ph_r && (!txe_r || !master)) &&
        !(crc_on && !crc_ph_r && !en);

    // ------------------------------------------------------------------
    // Data, CRC and flags
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txd_r <= '0;
            txe_r <= 1'b1;
        end else if (pclken) begin
            if (wr && paddr == SSP_OFS_DATA) begin
                txd_r <= pwdata[DW-1:0];
                txe_r <= 1'b0;
            end else if (ev.load) begin
                txe_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rxd_r <= '0;
            receive_not_empty_flag_r <= 1'b0;
        end else if (pclken) begin
            if (ev.word) begin
                rxd_r <= sh_r;
                receive_not_empty_flag_r <= 1'b1;
            end else if (rd && paddr == SSP_OFS_DATA) begin
                receive_not_empty_flag_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rcrc_r <= 16'h0000;
            tcrc_r <= 16'h0000;
            checksum_error_flag_r <= 1'b0;
        end else if (pclken) begin
            if (st_r == SHIFT && smp && !crc_ph_r && crc_on) begin
                rcrc_r <= crc_step(rcrc_r, pin_s.sd, crcp_r);
                tcrc_r <= crc_step(tcrc_r, sh_r[DW-1], crcp_r);
            end
            if (st_r == SHIFT && last_r && !smp && crc_ph_r &&
                    sh_r != rcrc_r[DW-1:0]) begin
                checksum_error_flag_r <= 1'b1;
            end else if (wr && paddr == SSP_OFS_STAT &&
                    pwdata[SSP_ST_CHECKSUM_ERROR_FLAG]) begin
                checksum_error_flag_r <= 1'b0;
            end
            if (wr && paddr == SSP_OFS_RCRC) begin
                rcrc_r <= 16'h0000;
                tcrc_r <= 16'h0000;
            end
        end
    end

    // ------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irqs_r <= '0;
        end else if (pclken) begin
            for (int i = 0; i < SSP_EV_W; i++) begin
                if (wr && paddr == SSP_OFS_IRQS && pwdata[i]) begin
                    irqs_r[i] <= 1'b0;
                end
            end
            // Set beats a simultaneous clear
            if (ev.load) irqs_r[SSP_EV_TXE] <= 1'b1;
            if (ev.word) irqs_r[SSP_EV_RECEIVE_NOT_EMPTY_FLAG] <= 1'b1;
            if (ev.done) irqs_r[SSP_EV_DONE] <= 1'b1;
            if (st_r == SHIFT && last_r && !smp && crc_ph_r &&
                    sh_r != rcrc_r[DW-1:0]) begin
                irqs_r[SSP_EV_CHECKSUM_ERROR_FLAG] <= 1'b1;
            end
        end
    end

    assign irq = |(irqs_r & imsk_r);

    // ------------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out <= '0;
            pin_oe <= '0;
        end else if (pclken) begin
            pin_out.sck <= msck_r;
            pin_out.ws <= master ? mws_r : 1'b0;
            if (st_r != SHIFT || drv || bit_r == 6'h00) begin
                pin_out.sd <= sh_r[DW-1];
            end
            pin_oe.sck <= master & (en | st_r != IDLE);
            pin_oe.ws <= master & (en | st_r != IDLE) & i2s;
            pin_oe.sd <= (en | st_r != IDLE) & ~ctrl_r[SSP_CTL_RXONLY];
        end
    end

endmodule : ssp_port
`default_nettype wire

// >>> hdl/ssp_pkg.sv
// Package: register map, field layout and types of the serial port
package ssp_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] SSP_OFS_CTRL = 8'h00;
    localparam logic [7:0] SSP_OFS_STAT = 8'h04;
    localparam logic [7:0] SSP_OFS_DATA = 8'h08;
    localparam logic [7:0] SSP_OFS_CRCP = 8'h0c;
    localparam logic [7:0] SSP_OFS_RCRC = 8'h10;
    localparam logic [7:0] SSP_OFS_TCRC = 8'h14;
    localparam logic [7:0] SSP_OFS_IRQS = 8'h18;
    localparam logic [7:0] SSP_OFS_IMSK = 8'h1c;

    // ------------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------------
    localparam int SSP_CTL_EN = 0;
    localparam int SSP_CTL_MST = 1;
    localparam int SSP_CTL_I2S = 2;
    localparam int SSP_CTL_STD0 = 3;
    localparam int SSP_CTL_CRCEN = 5;
    localparam int SSP_CTL_RXONLY = 6;
    localparam int SSP_CTL_CPOL = 7;
    localparam int SSP_CTL_DIV0 = 8;
    localparam int SSP_CTL_W = 16;

    // Status fields
    localparam int SSP_ST_TXE = 0;
    localparam int SSP_ST_RECEIVE_NOT_EMPTY_FLAG = 1;
    localparam int SSP_ST_BSY = 2;
    localparam int SSP_ST_CHECKSUM_ERROR_FLAG = 3;

    // Interrupt event bits
    localparam int SSP_EV_TXE = 0;
    localparam int SSP_EV_RECEIVE_NOT_EMPTY_FLAG = 1;
    localparam int SSP_EV_DONE = 2;
    localparam int SSP_EV_CHECKSUM_ERROR_FLAG = 3;
    localparam int SSP_EV_W = 4;

    // Reset values
    localparam logic [15:0] SSP_CTRL_RST = 16'h0000;
    localparam logic [15:0] SSP_CRCP_RST = 16'h0007;

    // I2S standards
    typedef enum logic [1:0] {
        SSP_STD_PHILIPS = 2'b00,
        SSP_STD_MSB = 2'b01,
        SSP_STD_LSB = 2'b10
    } ssp_std_t;

    // Serial pins as one carrier
    typedef struct packed {
        logic sck;
        logic ws;
        logic sd;
    } ssp_pins_t;

    // Events from the shift engine
    typedef struct packed {
        logic load;
        logic word;
        logic done;
    } ssp_ev_t;

endpackage : ssp_pkg

// >>> hdl/ssp_sync.sv
// Two-flop synchroniser for the serial pins
`timescale 1ns/1ps
`default_nettype none
module ssp_sync #(
    parameter int W = 3
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= '0;
            q <= '0;
        end else if (ce) begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule : ssp_sync
`default_nettype wire

// >>> tb/ssp_port_props.sv
// Checker of the serial port bus and pin behaviour
`timescale 1ns/1ps
`default_nettype none
module ssp_port_props
    import ssp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pclken,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire ssp_pkg::ssp_pins_t pin_out,
    input wire ssp_pkg::ssp_pins_t pin_oe,
    input wire logic irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ----------
    // Shadows
    // ----------
    logic wr_ok;
    logic bad_a;
    logic mst_seen;
    logic msk_z;
    assign wr_ok = psel && penable && pwrite && pclken;
    assign bad_a = paddr > 8'h1c || paddr[1:0] != 2'h0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mst_seen <= 1'b0;
        end else if (wr_ok && paddr == SSP_OFS_CTRL && pwdata[1]) begin
            mst_seen <= 1'b1;
        end
    end
    // Mask shadow updates on the same edge as the mask; the rule still waits two cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            msk_z <= 1'b1;
        end else if (wr_ok && paddr == SSP_OFS_IMSK) begin
            msk_z <= pwdata[3:0] == 4'h0;
        end
    end
    ready_zero_wait_a: assert property (psel && penable |-> pready)
        else $error("pready low in access");
    err_bad_addr_a: assert property (psel && penable && bad_a |-> pslverr)
        else $error("no error on bad address");
    err_good_addr_a: assert property (psel && !bad_a |-> !pslverr)
        else $error("error on mapped address");
    err_read_zero_a: assert property (
        psel && penable && !pwrite && pslverr |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    read_hold_a: assert property (psel && penable |=> $stable(prdata))
        else $error("read data moved after access");
    freeze_pins_a: assert property (
        !pclken |=> $stable(pin_out) && $stable(pin_oe))
        else $error("pins moved while frozen");
    slave_clk_in_a: assert property (
        !mst_seen |-> !pin_oe.sck && !pin_oe.ws)
        else $error("slave drives clock or select");
    irq_masked_a: assert property (msk_z [*2] |-> !irq)
        else $error("irq with mask clear");
    reset_clean_a: assert property (
        $rose(presetn) |-> !irq && prdata == 32'h0)
        else $error("outputs not clean after reset");
endmodule : ssp_port_props
bind ssp_port ssp_port_props chk (
    .pclk(pclk), .presetn(presetn), .pclken(pclken), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq)
);
`default_nettype wire

// >>> tb/ssp_far_end.sv
// Model of the external serial master facing the port
`timescale 1ns/1ps
`default_nettype none
module ssp_far_end
    import ssp_pkg::*;
(
    output var ssp_pkg::ssp_pins_t to_dut,
    input wire ssp_pkg::ssp_pins_t from_dut
);
    logic [7:0] rx_word;
    initial begin
        to_dut = '0;
        rx_word = 8'h00;
    end
    task automatic set_ws(input logic lvl);
        to_dut.ws = lvl;
    endtask : set_ws
    // Clock stands still between calls; 32 ns bit period
    task automatic clk_bits(input logic [7:0] tx, input int n,
                            input logic flip);
        for (int i = 0; i < n; i++) begin
            to_dut.sd = tx[7-i];
            #16;
            to_dut.sck = 1'b1;
            if (flip && i == 2) to_dut.ws = ~to_dut.ws;
            #16;
            rx_word = {rx_word[6:0], from_dut.sd};
            to_dut.sck = 1'b0;
        end
        // Released line shows the inverse, not a held value
        to_dut.sd = ~to_dut.sd;
    endtask : clk_bits
endmodule : ssp_far_end
`default_nettype wire

// >>> tb/spi_i2s_serial_port_bench.sv
// Self-checking bench of the serial port
`timescale 1ns/1ps
`default_nettype none
module spi_i2s_serial_port_bench
    import ssp_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic pclken = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic err;
    logic [31:0] rd;
    ssp_pins_t far_pins;
    ssp_pins_t pin_in;
    ssp_pins_t pin_out;
    ssp_pins_t pin_oe;
    int err_count = 0;
    int checks = 0;
    int cyc = 0;
    always #2 pclk = ~pclk;
    // Shared data wire: the port wins while it drives
    assign pin_in = {far_pins.sck, far_pins.ws,
                     pin_oe.sd ? pin_out.sd : far_pins.sd};
    ssp_port #(.DW(8)) uut (
        .pclk(pclk), .presetn(presetn), .pclken(pclken), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .irq(irq)
    );
    ssp_far_end far (.to_dut(far_pins), .from_dut(pin_in));
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic poll(input int b, input logic v, input string what);
        int n = 0;
        do begin
            apb(1'b0, SSP_OFS_STAT, 32'h0);
            n++;
        end while (rd[b] !== v && n < 60);
        chk(what, 32'(v), 32'(rd[b]));
    endtask : poll
    task automatic irq_is(input logic v, input string what);
        repeat (2) @(posedge pclk);
        chk(what, 32'(v), 32'(irq));
    endtask : irq_is
    task automatic t_regs;
        apb(1'b0, SSP_OFS_CTRL, 32'h0);
        chk("ctrl reset", 32'h0, rd);
        apb(1'b0, SSP_OFS_CRCP, 32'h0);
        chk("poly reset", {16'h0, SSP_CRCP_RST}, rd);
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped err", 32'h1, 32'(err));
        chk("unmapped data", 32'h0, rd);
        pclken <= 1'b0;
        repeat (3) @(posedge pclk);
        pclken <= 1'b1;
    endtask : t_regs
    task automatic t_rx;
        apb(1'b1, SSP_OFS_IMSK, 32'h2);
        apb(1'b1, SSP_OFS_CTRL, 32'h41);
        far.clk_bits(8'ha5, 7, 1'b0);
        apb(1'b0, SSP_OFS_STAT, 32'h0);
        chk("receive_not_empty_flag early", 32'h0, 32'(rd[SSP_ST_RECEIVE_NOT_EMPTY_FLAG]));
        far.clk_bits(8'h80, 1, 1'b0);
        poll(SSP_ST_RECEIVE_NOT_EMPTY_FLAG, 1'b1, "receive_not_empty_flag");
        irq_is(1'b1, "irq on");
        poll(SSP_ST_BSY, 1'b0, "slave busy");
        apb(1'b0, SSP_OFS_DATA, 32'h0);
        chk("rx word", 32'ha5, rd);
        apb(1'b1, SSP_OFS_IMSK, 32'h0);
        irq_is(1'b0, "irq masked");
        apb(1'b1, SSP_OFS_IMSK, 32'h2);
        irq_is(1'b1, "irq unmasked");
        apb(1'b1, SSP_OFS_IRQS, 32'h2);
        irq_is(1'b0, "irq cleared");
    endtask : t_rx
    task automatic t_i2s;
        apb(1'b1, SSP_OFS_CTRL, 32'h0);
        far.set_ws(1'b0);
        apb(1'b1, SSP_OFS_CTRL, 32'h4d);
        far.clk_bits(8'h00, 1, 1'b0);
        far.set_ws(1'b1);
        far.clk_bits(8'h96, 8, 1'b1);
        poll(SSP_ST_RECEIVE_NOT_EMPTY_FLAG, 1'b1, "i2s receive_not_empty_flag");
        apb(1'b0, SSP_OFS_DATA, 32'h0);
        chk("i2s word", 32'h96, rd);
    endtask : t_i2s
    task automatic t_tx;
        apb(1'b1, SSP_OFS_CTRL, 32'h0);
        apb(1'b1, SSP_OFS_DATA, 32'h3c);
        apb(1'b1, SSP_OFS_CTRL, 32'h1);
        poll(SSP_ST_TXE, 1'b1, "txe");
        far.clk_bits(8'h00, 4, 1'b0);
        apb(1'b0, SSP_OFS_STAT, 32'h0);
        chk("busy mid", 32'h1, 32'(rd[SSP_ST_BSY]));
        apb(1'b1, SSP_OFS_CTRL, 32'h0);
        far.clk_bits(8'h00, 4, 1'b0);
        poll(SSP_ST_BSY, 1'b0, "busy end");
        chk("tx word", 32'h3c, {24'h0, far.rx_word});
    endtask : t_tx
    // Master loops its own data line back; CRC frame follows on disable
    task automatic t_mst;
        apb(1'b1, SSP_OFS_CTRL, 32'h0);
        apb(1'b1, SSP_OFS_DATA, 32'h5a);
        apb(1'b1, SSP_OFS_CTRL, 32'h323);
        poll(SSP_ST_TXE, 1'b1, "mst txe");
        apb(1'b1, SSP_OFS_CTRL, 32'h322);
        poll(SSP_ST_BSY, 1'b0, "mst busy end");
        chk("crc error", 32'h0, 32'(rd[SSP_ST_CHECKSUM_ERROR_FLAG]));
        apb(1'b0, SSP_OFS_DATA, 32'h0);
        chk("mst loop word", 32'h5a, rd);
    endtask : t_mst
    task automatic final_report;
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_rx;
        t_i2s;
        t_tx;
        t_mst;
        final_report;
    end
    // Whole run needs well under a thousand cycles
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            final_report;
        end
    end
endmodule : spi_i2s_serial_port_bench
`default_nettype wire
